// ### adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h78;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h79;
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h7a;
  localparam logic [7:0] ADDR_REF_CH_SEL  = 8'h7c;

  // reset values
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] REF_CH_SEL_RESET  = 8'h00;

  // converter_control_status bit positions
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_START    = 6;
  localparam int BIT_FREE_RUN = 5;
  localparam int BIT_DONE     = 4;

  // reference_channel_select field positions
  localparam int BIT_LEFT_JUSTIFY = 5;
  localparam int REF_SEL_LSB      = 6;
  localparam int CHAN_SEL_MSB     = 4;

  ////////////////////////////////////////////////////////////////////////////
  // conversion timing in converter clock cycles, divider ratio, result width
  localparam int FIRST_CONV_TICKS  = 25;
  localparam int NORMAL_CONV_TICKS = 13;
  localparam int SAMPLE_TICKS      = 2;
  localparam int INIT_TICKS        = FIRST_CONV_TICKS - NORMAL_CONV_TICKS;
  localparam int BIT_TICKS         = NORMAL_CONV_TICKS - SAMPLE_TICKS;
  localparam int CONV_CLK_DIV      = 8;
  localparam int RES_W             = 10;

  ////////////////////////////////////////////////////////////////////////////
  // reference selection codes
  localparam logic [1:0] REF_EXT_PIN  = 2'h0;
  localparam logic [1:0] REF_AVCC     = 2'h1;
  localparam logic [1:0] REF_INT_1V1  = 2'h2;
  localparam logic [1:0] REF_INT_2V56 = 2'h3;

  // channel code boundaries
  localparam logic [4:0] CH_DIFF_GAIN = 5'h08;
  localparam logic [4:0] CH_DIFF_1X   = 5'h10;
  localparam logic [4:0] CH_BANDGAP   = 5'h1e;
  localparam logic [4:0] CH_GROUND    = 5'h1f;

  // gain encodings driven to the gain stage
  localparam logic [1:0] GAIN_1X   = 2'h0;
  localparam logic [1:0] GAIN_10X  = 2'h1;
  localparam logic [1:0] GAIN_200X = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_INIT   = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_BITS   = 2'b11
  } conv_state_t;

endpackage

// ### conv_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none

module conv_clock_divider
  import adc_ctrl_pkg::*;
#(
  parameter int DIV = CONV_CLK_DIV
) (
  input  wire logic mclk,     // system clock
  input  wire logic reset_n,  // async reset, active low
  input  wire logic run,      // divider runs while high
  output var  logic tick      // one-cycle converter clock pulse
);

  localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;
  logic          tick_ff;
  logic          nxt_tick;

  // restart from zero whenever stopped so phase is known at power-up
  always_comb begin
    nxt_count = '0;
    nxt_tick  = 1'b0;
    if (run) begin
      nxt_count = (count_ff == LAST) ? '0 : count_ff + CW'(1);
      nxt_tick  = (count_ff == LAST);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff  <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

`default_nettype wire

// ### adc_mux_and_control_regs.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - reference change waits for conversion end
// - reference code picks pin, supply, 1.1, 2.56
// - justify bit reshapes result data at once
// - codes select single inputs, bandgap, ground
// - codes select differential pairs and gain
// - channel change waits for conversion end
// - enable bit powers converter on or off
// - disabling mid conversion aborts without result
// - single mode: one start, one conversion
// - free running: conversions repeat after start
// - first conversion 25 cycles, later 13
// - start bit reads one while busy
// - writing start zero is ignored
// - done flag set when data updated
// - left or right placement of result bits
// - low byte read locks data until high
// - differential results in two's complement
module adc_mux_and_control_regs
  import adc_ctrl_pkg::*;
#(
  parameter int DIV = CONV_CLK_DIV
) (
  input  wire logic             mclk,              // system clock, 40 MHz
  input  wire logic             reset_n,           // async reset, active low
  input  wire logic [7:0]       reg_addr,          // register byte address
  input  wire logic [7:0]       reg_wdata,         // write data
  input  wire logic             reg_wr,            // write strobe
  input  wire logic             reg_rd,            // read strobe
  output var  logic [7:0]       reg_rdata,         // read data, cycle after strobe
  input  wire logic             comparator_in,     // analog comparator, async
  output var  logic             converter_power,   // analog core powered
  output var  logic             sample_hold,       // high while holding sample
  output var  logic [RES_W-1:0] dac_code,          // trial code to the dac
  output var  logic             reference_pin_en,  // external reference pin
  output var  logic             ref_avcc_en,       // analog supply reference
  output var  logic             ref_int_1v1_en,    // internal 1.1 V reference
  output var  logic             ref_int_2v56_en,   // internal 2.56 V reference
  output var  logic [2:0]       pos_input,         // positive input number
  output var  logic [2:0]       neg_input,         // negative input number
  output var  logic [1:0]       gain_sel,          // gain stage setting
  output var  logic             differential,      // differential pair chosen
  output var  logic             bandgap_sel,       // bandgap on converter input
  output var  logic             ground_sel         // ground on converter input
);

  localparam logic [4:0] INIT_LAST   = 5'(INIT_TICKS - 1);
  localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_TICKS - 1);
  localparam logic [4:0] BITS_LAST   = 5'(BIT_TICKS - 1);
  localparam logic [3:0] TOP_BIT     = 4'(RES_W - 1);

  ////////////////////////////////////////////////////////////////////////////
  // shared nets
  logic             tick;
  logic             comp_meta_ff;
  logic             comp_sync_ff;
  logic             wr_ctrl;
  logic             wr_sel;
  logic             start_req;
  logic             abort;
  logic             complete;
  logic [RES_W-1:0] final_code;

  conv_state_t      state_ff;
  conv_state_t      nxt_state;
  logic [4:0]       cnt_ff;
  logic [4:0]       nxt_cnt;
  logic [RES_W-1:0] sar_ff;
  logic [RES_W-1:0] nxt_sar;
  logic [3:0]       idx_ff;
  logic [3:0]       nxt_idx;

  logic [7:0]       sel_ff;
  logic [7:0]       nxt_sel;
  logic             enable_ff;
  logic             nxt_enable;
  logic             free_run_ff;
  logic             nxt_free_run;
  logic             done_ff;
  logic             nxt_done;
  logic             first_ff;
  logic             nxt_first;
  logic             lock_ff;
  logic             nxt_lock;
  logic [RES_W-1:0] result_ff;
  logic [RES_W-1:0] nxt_result;
  logic [1:0]       ref_app_ff;
  logic [1:0]       nxt_ref_app;
  logic [4:0]       chan_app_ff;
  logic [4:0]       nxt_chan_app;
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;

  logic [3:0]       ref_out_ff;
  logic [3:0]       nxt_ref_out;
  logic [10:0]      mux_out_ff;
  logic [10:0]      nxt_mux_out;
  logic             hold_ff;
  logic             nxt_hold;

  ////////////////////////////////////////////////////////////////////////////
  // converter clock and comparator synchroniser; DIV must be 3 or more so each decision sees settled sync flops
  conv_clock_divider #(.DIV(DIV)) u_div (
    .mclk    (mclk),
    .reset_n (reset_n),
    .run     (enable_ff),
    .tick    (tick)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
    end else begin
      comp_meta_ff <= comparator_in;
      comp_sync_ff <= comp_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; a busy start write is absorbed, a zero start does nothing
  assign wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL_STATUS);
  assign wr_sel    = reg_wr && (reg_addr == ADDR_REF_CH_SEL);
  assign abort     = wr_ctrl && !reg_wdata[BIT_ENABLE];
  assign start_req = wr_ctrl && reg_wdata[BIT_ENABLE] && reg_wdata[BIT_START] && (state_ff == ST_IDLE);
  assign complete  = !abort && (state_ff == ST_BITS) && tick && (cnt_ff == BITS_LAST);
  assign final_code = (chan_app_ff >= CH_DIFF_GAIN && chan_app_ff < CH_BANDGAP)
                      ? {~sar_ff[RES_W-1], sar_ff[RES_W-2:0]} : sar_ff;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer: init, sample, ten bit decisions, finish
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sar   = sar_ff;
    nxt_idx   = idx_ff;
    if (abort) begin
      nxt_state = ST_IDLE;
      nxt_cnt   = '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_req) begin
            nxt_state = (first_ff || !enable_ff) ? ST_INIT : ST_SAMPLE;
            nxt_cnt   = '0;
          end
        end
        ST_INIT: begin
          if (tick) begin
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == INIT_LAST) begin
              nxt_state = ST_SAMPLE;
              nxt_cnt   = '0;
            end
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == SAMPLE_LAST) begin
              nxt_state = ST_BITS;
              nxt_cnt   = '0;
              nxt_sar   = {1'b1, {(RES_W-1){1'b0}}};
              nxt_idx   = TOP_BIT;
            end
          end
        end
        ST_BITS: begin
          if (tick) begin
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == BITS_LAST) begin
              nxt_state = free_run_ff ? ST_SAMPLE : ST_IDLE;
              nxt_cnt   = '0;
            end else begin
              nxt_sar[idx_ff] = comp_sync_ff;
              if (idx_ff != 4'h0) begin
                nxt_sar[idx_ff - 4'h1] = 1'b1;
                nxt_idx                = idx_ff - 4'h1;
              end
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_cnt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      sar_ff   <= '0;
      idx_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      sar_ff   <= nxt_sar;
      idx_ff   <= nxt_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers, shadows, result and read port
  always_comb begin
    nxt_sel      = sel_ff;
    nxt_enable   = enable_ff;
    nxt_free_run = free_run_ff;
    nxt_first    = first_ff;
    nxt_lock     = lock_ff;
    nxt_result   = result_ff;
    nxt_done     = done_ff;
    nxt_rdata    = 8'h00;
    nxt_ref_app  = ref_app_ff;
    nxt_chan_app = chan_app_ff;
    if (wr_sel) begin
      nxt_sel = reg_wdata;
    end
    if (wr_ctrl) begin
      nxt_enable   = reg_wdata[BIT_ENABLE];
      nxt_free_run = reg_wdata[BIT_FREE_RUN];
      if (reg_wdata[BIT_DONE]) begin
        nxt_done = 1'b0;
      end
    end
    if (abort || start_req) begin
      nxt_first = 1'b0;
    end else if (wr_ctrl && reg_wdata[BIT_ENABLE] && !enable_ff) begin
      nxt_first = 1'b1;
    end
    // low read locks until high read
    if (reg_rd && reg_addr == ADDR_RESULT_LOW) begin
      nxt_lock = 1'b1;
    end else if (reg_rd && reg_addr == ADDR_RESULT_HIGH) begin
      nxt_lock = 1'b0;
    end
    if (complete && !lock_ff) begin
      nxt_result = final_code;
      nxt_done   = 1'b1;
    end
    // shadows track only when idle or finishing
    if (state_ff == ST_IDLE || complete) begin
      nxt_ref_app  = sel_ff[7:REF_SEL_LSB];
      nxt_chan_app = sel_ff[CHAN_SEL_MSB:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_RESULT_LOW: begin
          nxt_rdata = sel_ff[BIT_LEFT_JUSTIFY] ? {result_ff[1:0], 6'h00} : result_ff[7:0];
        end
        ADDR_RESULT_HIGH: begin
          nxt_rdata = sel_ff[BIT_LEFT_JUSTIFY] ? result_ff[9:2] : {6'h00, result_ff[9:8]};
        end
        ADDR_CTRL_STATUS: begin
          nxt_rdata = {enable_ff, state_ff != ST_IDLE, free_run_ff, done_ff, 4'h0};
        end
        ADDR_REF_CH_SEL: begin
          nxt_rdata = sel_ff;
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sel_ff      <= REF_CH_SEL_RESET;
      enable_ff   <= CTRL_STATUS_RESET[BIT_ENABLE];
      free_run_ff <= CTRL_STATUS_RESET[BIT_FREE_RUN];
      done_ff     <= CTRL_STATUS_RESET[BIT_DONE];
      first_ff    <= 1'b0;
      lock_ff     <= 1'b0;
      result_ff   <= '0;
      ref_app_ff  <= REF_CH_SEL_RESET[7:REF_SEL_LSB];
      chan_app_ff <= REF_CH_SEL_RESET[CHAN_SEL_MSB:0];
      rdata_ff    <= 8'h00;
    end else begin
      sel_ff      <= nxt_sel;
      enable_ff   <= nxt_enable;
      free_run_ff <= nxt_free_run;
      done_ff     <= nxt_done;
      first_ff    <= nxt_first;
      lock_ff     <= nxt_lock;
      result_ff   <= nxt_result;
      ref_app_ff  <= nxt_ref_app;
      chan_app_ff <= nxt_chan_app;
      rdata_ff    <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog control outputs: reference and mux decoded from the shadows, hold from the next state
  always_comb begin
    nxt_ref_out = 4'h0;
    case (ref_app_ff)
      REF_EXT_PIN:  nxt_ref_out = 4'h1;
      REF_AVCC:     nxt_ref_out = 4'h2;
      REF_INT_1V1:  nxt_ref_out = 4'h4;
      REF_INT_2V56: nxt_ref_out = 4'h8;
      default:      nxt_ref_out = 4'h0;
    endcase
    // fields: {ground, bandgap, diff, gain[1:0], neg[2:0], pos[2:0]}
    nxt_mux_out = 11'h000;
    if (chan_app_ff == CH_GROUND) begin
      nxt_mux_out[10] = 1'b1;
    end else if (chan_app_ff == CH_BANDGAP) begin
      nxt_mux_out[9] = 1'b1;
    end else if (chan_app_ff >= CH_DIFF_1X) begin
      // unity gain, negative input 1 or 2
      nxt_mux_out = {2'b00, 1'b1, GAIN_1X, chan_app_ff[3] ? 3'h2 : 3'h1, chan_app_ff[2:0]};
    end else if (chan_app_ff >= CH_DIFF_GAIN) begin
      // gain pairs on input 0 or 2
      nxt_mux_out = {2'b00, 1'b1, chan_app_ff[1] ? GAIN_200X : GAIN_10X,
                     chan_app_ff[2] ? 3'h2 : 3'h0,
                     chan_app_ff[2] ? {2'b01, chan_app_ff[0]} : {2'b00, chan_app_ff[0]}};
    end else begin
      nxt_mux_out[2:0] = chan_app_ff[2:0];
    end
    nxt_hold = (nxt_state == ST_BITS);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ref_out_ff <= 4'h1;
      mux_out_ff <= 11'h000;
      hold_ff    <= 1'b0;
    end else begin
      ref_out_ff <= nxt_ref_out;
      mux_out_ff <= nxt_mux_out;
      hold_ff    <= nxt_hold;
    end
  end

  assign reg_rdata        = rdata_ff;
  assign converter_power  = enable_ff;
  assign sample_hold      = hold_ff;
  assign dac_code         = sar_ff;
  assign reference_pin_en = ref_out_ff[0];
  assign ref_avcc_en      = ref_out_ff[1];
  assign ref_int_1v1_en   = ref_out_ff[2];
  assign ref_int_2v56_en  = ref_out_ff[3];
  assign pos_input        = mux_out_ff[2:0];
  assign neg_input        = mux_out_ff[5:3];
  assign gain_sel         = mux_out_ff[7:6];
  assign differential     = mux_out_ff[8];
  assign bandgap_sel      = mux_out_ff[9];
  assign ground_sel       = mux_out_ff[10];

  ////////////////////////////////////////////////////////////////////////////
  // checks; a tick counter per conversion backs the length check
  logic [4:0] conv_ticks_ff;
  logic       conv_first_ff;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      conv_ticks_ff <= '0;
      conv_first_ff <= 1'b0;
    end else if (start_req || complete) begin
      conv_ticks_ff <= '0;
      conv_first_ff <= start_req && (first_ff || !enable_ff);
    end else if (tick && state_ff != ST_IDLE) begin
      conv_ticks_ff <= conv_ticks_ff + 5'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_ref_hold: assert property ((state_ff != ST_IDLE) && !complete |=> $stable(ref_app_ff))
    else $error("reference shadow changed mid conversion");
  chk_ref_decode: assert property ((ref_app_ff == REF_INT_2V56) |=> ref_int_2v56_en && !reference_pin_en)
    else $error("reference decode wrong");
  chk_justify_high: assert property (reg_rd && reg_addr == ADDR_RESULT_HIGH && sel_ff[BIT_LEFT_JUSTIFY]
    |=> reg_rdata == $past(result_ff[9:2]))
    else $error("left justified high byte wrong");
  chk_single_chan: assert property ((chan_app_ff < CH_DIFF_GAIN) |=> !differential && pos_input == $past(chan_app_ff[2:0]))
    else $error("single-ended decode wrong");
  chk_diff_gain: assert property ((chan_app_ff == 5'h0a) |=> differential && gain_sel == GAIN_200X && neg_input == 3'h0
    && pos_input == 3'h0)
    else $error("gain pair decode wrong");
  chk_chan_hold: assert property ((state_ff != ST_IDLE) && !complete |=> $stable(chan_app_ff))
    else $error("channel shadow changed mid conversion");
  chk_abort: assert property (abort && state_ff != ST_IDLE |=> state_ff == ST_IDLE && !converter_power ##1 !$rose(done_ff))
    else $error("disable did not abort cleanly");
  chk_conv_len: assert property (complete |-> conv_ticks_ff == (conv_first_ff ? 5'h18 : 5'h0c))
    else $error("conversion length wrong");
  chk_zero_start: assert property (wr_ctrl && reg_wdata[BIT_ENABLE] && !reg_wdata[BIT_START] && state_ff != ST_IDLE && !complete
    |=> state_ff != ST_IDLE)
    else $error("start zero disturbed conversion");
  chk_lock_hold: assert property (lock_ff && !(reg_rd && reg_addr == ADDR_RESULT_HIGH) |=> $stable(result_ff))
    else $error("result changed while locked");

  cov_first_conv: cover property (complete && conv_first_ff);
  cov_free_run:   cover property (complete && free_run_ff ##1 state_ff == ST_SAMPLE);
  cov_abort:      cover property (abort && state_ff == ST_BITS);
  cov_locked:     cover property (complete && lock_ff);

endmodule

`default_nettype wire

// ### analog_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module analog_core_model
  import adc_ctrl_pkg::*;
(
  input  wire logic             mclk,          // system clock
  input  wire logic             powered,       // core powered
  input  wire logic [RES_W-1:0] dac_code,      // trial code
  input  wire logic [RES_W-1:0] level,         // input voltage as code
  output var  logic             comparator_in  // 1 when input >= trial
);
  logic toggle_ff = 1'b0;

  // unpowered comparator gives junk, so it must not settle
  always_ff @(posedge mclk) begin
    toggle_ff <= !toggle_ff;
  end

  // differential twos complement comes from the design flipping the msb
  assign comparator_in = powered ? (level >= dac_code) : toggle_ff;
endmodule

`default_nettype wire

// ### adc_mux_and_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module adc_mux_and_control_regs_tb;
  import adc_ctrl_pkg::*;
  // divide by four: the comparator's two sync flops need three clocks per decision
  localparam int D     = 4;
  localparam int LIMIT = 20000;
  logic       mclk, reset_n, reg_wr, reg_rd, comparator_in, converter_power, sample_hold;
  logic       reference_pin_en, ref_avcc_en, ref_int_1v1_en, ref_int_2v56_en;
  logic       differential, bandgap_sel, ground_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [9:0] dac_code, level;
  logic [2:0] pos_input, neg_input;
  logic [1:0] gain_sel;
  int         cyc, t0, n, held, checks, miscompares;
  wire [14:0] sel = {reference_pin_en, ref_avcc_en, ref_int_1v1_en, ref_int_2v56_en,
                     pos_input, neg_input, gain_sel, differential, bandgap_sel, ground_sel};
  // select codes with expected decode and the bits that the decode defines
  localparam logic [7:0]  CODE [8] = '{8'h03, 8'h47, 8'h4d, 8'hca, 8'h13, 8'hdd, 8'h9e, 8'h1f};
  localparam logic [14:0] EXP  [8] = '{15'h4300, 15'h2700, 15'h234c, 15'h0814,
                                       15'h4324, 15'h0d44, 15'h1002, 15'h4001};
  localparam logic [14:0] MSK  [8] = '{15'h7f07, 15'h7f07, 15'h7fff, 15'h7fff,
                                       15'h7fff, 15'h7fff, 15'h7807, 15'h7807};

  adc_mux_and_control_regs #(.DIV(D)) dut (
    .mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .comparator_in,
    .converter_power, .sample_hold, .dac_code, .reference_pin_en, .ref_avcc_en,
    .ref_int_1v1_en, .ref_int_2v56_en, .pos_input, .neg_input, .gain_sel, .differential,
    .bandgap_sel, .ground_sel
  );

  analog_core_model partner (
    .mclk, .powered(converter_power), .dac_code, .level, .comparator_in
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // cycle count doubles as the hang guard; held counts cycles with the sample held
  always @(posedge mclk) begin
    cyc++;
    held += sample_hold;
    if (cyc == LIMIT) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, e, input string m);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk({8'h00, reg_rdata}, {8'h00, e}, m);
  endtask

  // poll a status bit, bounded; n is cycles since t0
  task automatic poll(input int b, input logic v);
    logic [7:0] d;
    d = v ? 8'h00 : 8'hff;
    for (int i = 0; i < 100 && d[b] !== v; i++) begin
      @(posedge mclk);
      reg_addr <= ADDR_CTRL_STATUS;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      d = reg_rdata;
    end
    n = cyc - t0;
    chk(d[b], v, "poll");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n   = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    level     = 10'h070;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    rchk(ADDR_CTRL_STATUS, CTRL_STATUS_RESET, "csr reset");
    rchk(ADDR_REF_CH_SEL, REF_CH_SEL_RESET, "sel reset");
    wr(8'h7b, 8'hff);
    rchk(8'h7b, 8'h00, "unmapped");
    rchk(ADDR_RESULT_HIGH, 8'h00, "result reset");
    chk(sel[14:11], 4'h8, "ref reset");
    // no external reference is driven, so internal codes are safe; diff pairs use the pin, supply and 2.56 V references
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_REF_CH_SEL, CODE[i]);
      repeat (3) @(posedge mclk);
      chk(sel & MSK[i], EXP[i], "decode");
    end
    // first conversion: diff 10x, 2.56 V, left justified
    wr(ADDR_REF_CH_SEL, 8'hed);
    wr(ADDR_CTRL_STATUS, 8'hc0);
    t0 = cyc;
    poll(BIT_START, 1'b0);
    chk(n >= 24 * D && n <= 26 * D + 6, 1, "first length");
    chk(held, BIT_TICKS * D, "hold time");
    rchk(ADDR_CTRL_STATUS, 8'h90, "done set");
    chk(converter_power, 1, "power on");
    rchk(ADDR_RESULT_LOW, 8'h00, "left low");
    rchk(ADDR_RESULT_HIGH, 8'h9c, "left high");
    wr(ADDR_REF_CH_SEL, 8'hcd);
    rchk(ADDR_RESULT_LOW, 8'h70, "right low");
    rchk(ADDR_RESULT_HIGH, 8'h02, "right high");
    // selection writes and start zero while busy
    level <= 10'h0f0;
    wr(ADDR_CTRL_STATUS, 8'hd0);
    t0 = cyc;
    wr(ADDR_REF_CH_SEL, 8'h03);
    wr(ADDR_CTRL_STATUS, 8'h80);
    rchk(ADDR_CTRL_STATUS, 8'hc0, "busy kept");
    chk(sel[14:11], 4'h1, "ref held");
    chk(differential, 1, "channel held");
    poll(BIT_START, 1'b0);
    chk(n >= 12 * D && n <= 14 * D + 6, 1, "normal length");
    repeat (3) @(posedge mclk);
    chk(sel[14:11], 4'h8, "ref applied");
    chk(differential, 0, "channel applied");
    rchk(ADDR_RESULT_LOW, 8'hf0, "new low");
    // low byte read locks the result until the high byte
    level <= 10'h155;
    rchk(ADDR_RESULT_LOW, 8'hf0, "lock low");
    wr(ADDR_CTRL_STATUS, 8'hd0);
    t0 = cyc;
    poll(BIT_START, 1'b0);
    rchk(ADDR_CTRL_STATUS, 8'h80, "no done locked");
    rchk(ADDR_RESULT_HIGH, 8'h02, "old high");
    wr(ADDR_CTRL_STATUS, 8'hd0);
    poll(BIT_START, 1'b0);
    rchk(ADDR_RESULT_LOW, 8'h55, "single low");
    rchk(ADDR_RESULT_HIGH, 8'h01, "single high");
    // free running repeats without start writes
    wr(ADDR_CTRL_STATUS, 8'hf0);
    poll(BIT_DONE, 1'b1);
    wr(ADDR_CTRL_STATUS, 8'hb0);
    poll(BIT_DONE, 1'b1);
    wr(ADDR_CTRL_STATUS, 8'h80);
    poll(BIT_START, 1'b0);
    // abort by disable, then start without enable
    level <= 10'h3aa;
    wr(ADDR_CTRL_STATUS, 8'hd0);
    repeat (6) @(posedge mclk);
    wr(ADDR_CTRL_STATUS, 8'h10);
    rchk(ADDR_CTRL_STATUS, 8'h00, "aborted");
    wr(ADDR_CTRL_STATUS, 8'h40);
    repeat (30 * D) @(posedge mclk);
    rchk(ADDR_CTRL_STATUS, 8'h00, "no result");
    chk(converter_power, 0, "power off");
    rchk(ADDR_RESULT_LOW, 8'h55, "data kept");
    rchk(ADDR_RESULT_HIGH, 8'h01, "data kept");
    final_report();
  end
endmodule

`default_nettype wire
